// *** verilog/rt_host_pkg.sv ***
// Shared types and constants for the remote terminal host register block
`default_nettype none
package rt_host_pkg;
  localparam int DATA_W  = 16;
  localparam int CTRL_W  = 8;
  localparam int FIELD_W = 5;
  localparam int LCMD_W  = 11;

  // Host pins as seen at the block boundary
  typedef struct packed {
    logic              cs_n;
    logic              ctrl_n;
    logic              rd_wr;
    logic              addr0;
    logic [DATA_W-1:0] data;
  } host_bus_t;
  localparam host_bus_t HOST_IDLE = 20'hC0000;

  // Write-only operation_control, bit 7 down to bit 0
  typedef struct packed {
    logic service_request;
    logic self_test_enable;
    logic diag_channel_pick;
    logic dependent_unit_busy;
    logic system_busy;
    logic terminal_flag;
    logic second_channel_enable;
    logic first_channel_enable;
  } control_reg_t;
  localparam control_reg_t CTRL_RESET = 8'h00;

  // Read-only terminal_status, bit 15 down to bit 0
  typedef struct packed {
    logic               terminal_active;
    logic               valid_message;
    logic               message_error;
    logic               address_parity_error;
    logic               self_test;
    logic               busy;
    logic               flag_allowed;
    logic               first_channel_avail;
    logic               second_channel_avail;
    logic               last_channel_indicator;
    logic               mode_or_sub_flag;
    logic [FIELD_W-1:0] mode_sub_field;
  } terminal_status_t;
  localparam terminal_status_t STATUS_RESET = 16'h0240;

  // Last command register, read with the low address bit high
  typedef struct packed {
    logic              illegal_command;
    logic              last_channel_indicator;
    logic              flag_allowed;
    logic              self_test;
    logic              busy;
    logic [LCMD_W-1:0] command_bits;
  } last_command_t;
  localparam last_command_t LAST_CMD_RESET = 16'hE7FF;

  // Decoded command handed over by the command recognition logic
  typedef struct packed {
    logic [LCMD_W-1:0]  command_bits;
    logic [FIELD_W-1:0] mode_sub_field;
    logic               mode_or_sub_flag;
    logic               on_first_channel;
    logic               illegal_command;
  } cmd_info_t;

  // Flags carried in the transmitted status word
  typedef struct packed {
    logic terminal_flag;
    logic busy;
    logic dependent_unit_busy;
    logic service_request;
  } status_flags_t;
  localparam status_flags_t FLAGS_RESET = 4'h0;

  // Idle level of transmitting_n, receiving_n, command_strobe_n
  localparam logic [2:0] LINE_IDLE = 3'h7;
endpackage
`default_nettype wire

// *** verilog/bit_sync2.sv ***
// Two-flop synchroniser for pins arriving from outside the clock domain
`default_nettype none
module bit_sync2 #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_sys, // System clock
  input  wire logic             rst,     // Synchronous reset
  input  wire logic             ce,      // Clock enable
  input  wire logic [WIDTH-1:0] d,       // Asynchronous input
  output logic      [WIDTH-1:0] q        // Synchronised output
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // First stage feeds only the second stage
  always_comb begin
    next_state = state;
    if (rst) begin
      next_state.first  = RESET_VAL;
      next_state.second = RESET_VAL;
    end else if (ce) begin
      next_state.first  = d;
      next_state.second = state.first;
    end
  end

  always_ff @(posedge clk_sys) begin
    state <= next_state;
  end

  assign q = state.second;
endmodule
`default_nettype wire

// *** verilog/sticky_event_flag.sv ***
// Sticky event flag cleared by a read once its holding condition is gone
`default_nettype none
module sticky_event_flag (
  input  wire logic clk_sys, // System clock
  input  wire logic rst,     // Synchronous reset, hard or soft
  input  wire logic ce,      // Clock enable
  input  wire logic set,     // Event pulse
  input  wire logic clear,   // End of a status read
  input  wire logic hold,    // Condition still present, defers the clear
  output logic      flag     // Sticky flag
);
  typedef struct packed {
    logic flag;
    logic armed;
  } sticky_state_t;

  sticky_state_t state;
  sticky_state_t next_state;
  logic          arm_now;

  // A read arms the clear; an arriving event wins and needs a fresh read
  always_comb begin
    arm_now    = state.armed | clear;
    next_state = state;
    if (rst) begin
      next_state = '0;
    end else if (ce) begin
      if (set) begin
        next_state.flag  = 1'b1;
        next_state.armed = 1'b0;
      end else if (arm_now && !hold) begin
        next_state.flag  = 1'b0;
        next_state.armed = 1'b0;
      end else begin
        next_state.armed = arm_now & state.flag;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    state <= next_state;
  end

  assign flag = state.flag;
endmodule
`default_nettype wire

// *** verilog/remote_terminal_host_registers.sv ***
// Host register bank of the remote terminal: control, status and last command
//
// Summary of operation
// - Host write with low address bit low loads data 7:0 into control.
// - Host write with low address bit high causes a master reset instead.
// - Control bits 0 and 1 enable channel A and B receive inputs.
// - Control bit 2 sets the terminal flag of the status word.
// - Control bit 3 sets busy and blocks data memory access, command kept.
// - Control bit 4 sets the subsystem flag of the status word.
// - Control bit 5 picks self-test channel: one is A, zero is B.
// - Control bit 6 enters self-test, suspends operation, outputs stay quiet.
// - Control bit 7 sets the service request bit of the status word.
// - Reset clears control and status, except channel and flag-allowed bits.
// - Host read with low address bit low returns the 16-bit status.
// - Status 4:0 hold last command field; bit 5 marks subaddress.
// - Status bit 6 is one when last command came on channel A.
// - Status bits 7 and 8 show channel B and channel A available.
// - Status bit 9 stays one until an inhibit-flag mode code arrives.
// - Status bit 10 shows busy, clearing only with the control bit.
// - Status bit 11 is one while self-test is active.
// - Status bit 12 flags bad address parity, blocks inputs, errors.
// - Status bit 13 latches errors until read and condition gone.
// - Status bit 14 latches valid messages until the status is read.
// - Status bit 15 is NAND of transmitting and receiving pins.
// - Host read with low address bit high returns last command register.
`default_nettype none
module remote_terminal_host_registers
  import rt_host_pkg::*;
(
  input  wire logic                      clk_sys,              // System clock
  input  wire logic                      rst,                  // Sync reset
  input  wire logic                      ce,                   // Clock enable
  input  wire rt_host_pkg::host_bus_t    host_in,              // Host pins
  output logic [rt_host_pkg::DATA_W-1:0] data_out,             // Read data
  output logic                           data_oe,              // Drive data
  input  wire logic                      cmd_valid,            // Command pulse
  input  wire rt_host_pkg::cmd_info_t    cmd_in,               // Command
  input  wire logic                      inhibit_flag_cmd,     // Inhibit mode
  input  wire logic                      override_inhibit_cmd, // Override
  input  wire logic                      message_error_evt,    // Error pulse
  input  wire logic                      message_error_cond,   // Error level
  input  wire logic                      valid_message_evt,    // Valid pulse
  input  wire logic                      addr_latch_load,      // Address load
  input  wire logic                      addr_parity_ok,       // Parity good
  input  wire logic                      transmitting_n,       // Pin, low
  input  wire logic                      receiving_n,          // Pin, low
  input  wire logic                      command_strobe_n,     // Pin, low
  output rt_host_pkg::status_flags_t     status_flags,         // Status word
  output logic                           first_channel_rx_en,  // Chan A in
  output logic                           second_channel_rx_en, // Chan B in
  output logic                           biphase_tx_en,        // Outputs on
  output logic                           self_test_active,     // Self-test
  output logic                           diag_channel_pick,    // 1 = chan A
  output logic                           memory_inhibit,       // No data DMA
  output logic                           master_reset          // Reset pulse
);
  import rt_host_pkg::*;

  typedef struct packed {
    control_reg_t       ctrl;
    logic [FIELD_W-1:0] field;
    logic               mode_or_sub;
    logic               chan_a;
    logic               flag_allowed;
    logic               parity_err;
    logic               term_active;
    last_command_t      lcmd;
    logic               wr_prev;
    logic               wr_done;
    logic               rd_prev;
    logic               rd_addr0;
    logic               strobe_prev;
    status_flags_t      flags;
    logic [DATA_W-1:0]  dout;
    logic               doe;
    logic               rx_a;
    logic               rx_b;
    logic               tx_en;
    logic               mreset;
  } state_t;

  state_t           q;
  state_t           next_q;
  host_bus_t        bus;
  logic [2:0]       lines;
  logic             wr;
  logic             rd;
  logic             wr_fire;
  logic             soft_rst;
  logic             rd_end;
  logic             strobe_rise;
  logic             msg_err;
  logic             valid_msg;
  logic             bad_parity;
  terminal_status_t sys_view;

  bit_sync2 #(
    .WIDTH     ($bits(host_bus_t)),
    .RESET_VAL (HOST_IDLE)
  ) u_host_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .d       (host_in),
    .q       (bus)
  );

  bit_sync2 #(
    .WIDTH     (3),
    .RESET_VAL (LINE_IDLE)
  ) u_line_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .d       ({transmitting_n, receiving_n, command_strobe_n}),
    .q       (lines)
  );

  assign wr          = !bus.cs_n && !bus.ctrl_n && !bus.rd_wr;
  assign rd          = !bus.cs_n && !bus.ctrl_n && bus.rd_wr;
  // Act on the second stable sample so data has settled with the strobes
  assign wr_fire     = ce && wr && q.wr_prev && !q.wr_done;
  assign soft_rst    = wr_fire && bus.addr0;
  assign rd_end      = ce && q.rd_prev && !rd && !q.rd_addr0;
  assign strobe_rise = ce && lines[0] && !q.strobe_prev;
  // wrong parity on an address load
  assign bad_parity  = addr_latch_load && !addr_parity_ok;

  // error latch held until read and gone
  sticky_event_flag u_msg_err (
    .clk_sys (clk_sys),
    .rst     (rst || soft_rst),
    .ce      (ce),
    .set     (message_error_evt || bad_parity || q.parity_err),
    .clear   (rd_end),
    .hold    (message_error_cond || q.parity_err),
    .flag    (msg_err)
  );

  sticky_event_flag u_valid_msg (
    .clk_sys (clk_sys),
    .rst     (rst || soft_rst),
    .ce      (ce),
    .set     (valid_message_evt),
    .clear   (rd_end),
    .hold    (1'b0),
    .flag    (valid_msg)
  );

  // Status assembled from live state
  always_comb begin
    sys_view                        = STATUS_RESET;
    sys_view.terminal_active        = q.term_active;
    sys_view.valid_message          = valid_msg;
    sys_view.message_error          = msg_err;
    sys_view.address_parity_error   = q.parity_err;
    sys_view.self_test              = q.ctrl.self_test_enable;
    // busy follows the control bit only
    sys_view.busy                   = q.ctrl.system_busy;
    sys_view.flag_allowed           = q.flag_allowed;
    sys_view.first_channel_avail    = q.ctrl.first_channel_enable && !q.parity_err;
    sys_view.second_channel_avail   = q.ctrl.second_channel_enable && !q.parity_err;
    sys_view.last_channel_indicator = q.chan_a;
    sys_view.mode_or_sub_flag       = q.mode_or_sub;
    sys_view.mode_sub_field         = q.field;
  end

  always_comb begin
    next_q = q;
    if (ce) begin
      next_q.wr_prev     = wr;
      next_q.wr_done     = wr && (q.wr_done || wr_fire);
      next_q.rd_prev     = rd;
      next_q.strobe_prev = lines[0];
      if (rd) begin
        next_q.rd_addr0 = bus.addr0;
      end
      // control load from low data byte
      if (wr_fire && !bus.addr0) begin
        next_q.ctrl = bus.data[CTRL_W-1:0];
      end
      next_q.doe  = rd;
      next_q.dout = bus.addr0 ? q.lcmd : sys_view;
      // active while either pin is low
      next_q.term_active = ~(lines[2] & lines[1]);
      if (cmd_valid) begin
        next_q.field                       = cmd_in.mode_sub_field;
        next_q.mode_or_sub                 = cmd_in.mode_or_sub_flag;
        next_q.chan_a                      = cmd_in.on_first_channel;
        next_q.lcmd.command_bits           = cmd_in.command_bits;
        next_q.lcmd.busy                   = q.ctrl.system_busy;
        next_q.lcmd.self_test              = q.ctrl.self_test_enable;
        next_q.lcmd.flag_allowed           = q.flag_allowed;
        next_q.lcmd.last_channel_indicator = cmd_in.on_first_channel;
        next_q.lcmd.illegal_command        = cmd_in.illegal_command;
      end
      // bus controller may withdraw the host flag
      if (inhibit_flag_cmd) begin
        next_q.flag_allowed = 1'b0;
      end else if (override_inhibit_cmd) begin
        next_q.flag_allowed = 1'b1;
      end
      // cleared only by a good reload or a reset
      if (addr_latch_load) begin
        next_q.parity_err = !addr_parity_ok;
      end
      // flags sampled at strobe rise; a late write misses this word
      if (strobe_rise) begin
        // terminal flag, gated by the controller
        next_q.flags.terminal_flag       = q.ctrl.terminal_flag && q.flag_allowed;
        next_q.flags.busy                = q.ctrl.system_busy;
        next_q.flags.dependent_unit_busy = q.ctrl.dependent_unit_busy;
        next_q.flags.service_request     = q.ctrl.service_request;
      end
      // inputs enabled unless parity fault or self-test
      next_q.rx_a  = q.ctrl.first_channel_enable && !q.parity_err &&
                     !q.ctrl.self_test_enable;
      next_q.rx_b  = q.ctrl.second_channel_enable && !q.parity_err &&
                     !q.ctrl.self_test_enable;
      // self-test never reaches the line drivers
      next_q.tx_en = !q.ctrl.self_test_enable;
    end
    // reset values; soft reset keeps the write tracker so it fires once
    if (rst || soft_rst) begin
      next_q.ctrl         = CTRL_RESET;
      next_q.field        = STATUS_RESET.mode_sub_field;
      next_q.mode_or_sub  = STATUS_RESET.mode_or_sub_flag;
      next_q.chan_a       = STATUS_RESET.last_channel_indicator;
      next_q.flag_allowed = STATUS_RESET.flag_allowed;
      next_q.parity_err   = STATUS_RESET.address_parity_error;
      next_q.term_active  = STATUS_RESET.terminal_active;
      next_q.lcmd         = LAST_CMD_RESET;
      next_q.rd_prev      = 1'b0;
      next_q.rd_addr0     = 1'b0;
      next_q.strobe_prev  = LINE_IDLE[0];
      next_q.flags        = FLAGS_RESET;
      next_q.dout         = '0;
      next_q.doe          = 1'b0;
      next_q.rx_a         = 1'b0;
      next_q.rx_b         = 1'b0;
      next_q.tx_en        = 1'b1;
    end
    if (rst) begin
      next_q.wr_prev = 1'b0;
      next_q.wr_done = 1'b0;
    end
    next_q.mreset = soft_rst;
  end

  always_ff @(posedge clk_sys) begin
    q <= next_q;
  end

  assign data_out             = q.dout;
  assign data_oe              = q.doe;
  assign status_flags         = q.flags;
  assign first_channel_rx_en  = q.rx_a;
  assign second_channel_rx_en = q.rx_b;
  assign biphase_tx_en        = q.tx_en;
  assign self_test_active     = q.ctrl.self_test_enable;
  assign diag_channel_pick    = q.ctrl.diag_channel_pick;
  assign memory_inhibit       = q.ctrl.system_busy;
  assign master_reset         = q.mreset;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_CTRL_LOAD: assert property (wr_fire && !bus.addr0 |=>
    q.ctrl == $past(bus.data[CTRL_W-1:0]) && !q.mreset)
    else $error("control write not loaded");
  AST_MASTER_RESET: assert property (soft_rst |=>
    q.mreset && q.ctrl == CTRL_RESET && q.lcmd == LAST_CMD_RESET ##1 !q.mreset)
    else $error("master reset write misbehaved");
  AST_RX_GATE: assert property (ce && bad_parity && !soft_rst |=>
    q.parity_err ##1 (!first_channel_rx_en && !second_channel_rx_en))
    else $error("parity error left inputs enabled");
  AST_STROBE_FLAGS: assert property (strobe_rise && !soft_rst |=>
    status_flags.service_request == $past(q.ctrl.service_request) &&
    status_flags.terminal_flag == $past(q.ctrl.terminal_flag && q.flag_allowed))
    else $error("status word flags not latched at strobe");
  // A master reset restores the line drivers even while self-test was set
  AST_SELF_TEST_QUIET: assert property (ce && q.ctrl.self_test_enable && !soft_rst |=>
    !biphase_tx_en && !first_channel_rx_en)
    else $error("self-test reached line drivers");
  AST_STATUS_READ: assert property (ce && rd && !bus.addr0 |=>
    data_oe && data_out == $past(sys_view))
    else $error("status read returned wrong data");
  AST_WRITE_NO_DRIVE: assert property (ce && wr |=> !data_oe)
    else $error("data driven during write");
  // A read ending right after the event may legally clear it one cycle later
  AST_VALID_STICKY: assert property (ce && valid_message_evt && !soft_rst |=>
    valid_msg ##1 (valid_msg || $past(rd_end || soft_rst)))
    else $error("valid message flag lost");
  AST_FLAG_INHIBIT: assert property (ce && inhibit_flag_cmd && !soft_rst |=>
    !q.flag_allowed)
    else $error("flag-allowed not cleared by inhibit");
  AST_ACTIVE_NAND: assert property ($past(ce && !rst && !soft_rst)
    |-> q.term_active == ~($past(lines[2]) & $past(lines[1])))
    else $error("terminal active not NAND of pins");

  CVR_CTRL_WRITE: cover property (wr_fire && !bus.addr0);
  CVR_SOFT_RESET: cover property (soft_rst);
  CVR_STATUS_READ_CLEAR: cover property (valid_msg ##1 rd_end ##1 !valid_msg);
  CVR_LAST_CMD_READ: cover property (ce && rd && bus.addr0 ##1 data_oe);
endmodule
`default_nettype wire

// *** sim/host_cpu_model.sv ***
// Host processor model that runs register accesses on the select pins
`default_nettype none
module host_cpu_model
  import rt_host_pkg::*;
(
  input  wire logic                           clk_sys,  // System clock
  input  wire logic                           data_oe,  // Block drives data
  input  wire logic [rt_host_pkg::DATA_W-1:0] data_out, // Read data
  output var  rt_host_pkg::host_bus_t         host_in   // Host pins
);
  timeunit 1ns;
  timeprecision 100ps;

  initial host_in = HOST_IDLE;

  task automatic access(input logic rd, input logic a0, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q, output logic to);
    int n;
    q = '0;
    to = rd;
    @(posedge clk_sys);
    #1;
    // A released data bus shows the inverse of its last value, never a stale copy
    host_in = '{1'b0, 1'b0, rd, a0, rd ? ~host_in.data : d};
    // Writes are held well past the two-sample capture; reads end on the answer
    for (n = 0; n < 8; n++) begin
      @(posedge clk_sys);
      if (rd && data_oe === 1'b1) begin
        q = data_out;
        to = 1'b0;
        break;
      end
    end
    #1;
    host_in = '{1'b1, 1'b1, 1'b1, 1'b0, ~host_in.data};
    repeat (5) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench of the remote terminal host register bank
`default_nettype none
module tb_top
  import rt_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [15:0] ST_EXP [8] = '{16'h0340, 16'h02C0, 16'h0240, 16'h0640,
                                         16'h0240, 16'h0240, 16'h0A40, 16'h0240};
  localparam logic [3:0]  FLG_EXP [8] = '{4'h0, 4'h0, 4'h8, 4'h4, 4'h2, 4'h0, 4'h0, 4'h1};
  localparam logic [5:0]  OUT_EXP [8] = '{6'h21, 6'h11, 6'h01, 6'h09,
                                         6'h01, 6'h05, 6'h02, 6'h01};

  logic          clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0;
  logic          inhibit_flag_cmd = 1'b0, override_inhibit_cmd = 1'b0;
  logic          message_error_evt = 1'b0, message_error_cond = 1'b0;
  logic          valid_message_evt = 1'b0, addr_latch_load = 1'b0, addr_parity_ok = 1'b1;
  logic          transmitting_n = 1'b1, receiving_n = 1'b1, command_strobe_n = 1'b1;
  cmd_info_t     cmd_in = '0;
  host_bus_t     host_in;
  logic [15:0]   data_out, mr_cnt = 16'h0000;
  logic          data_oe, first_channel_rx_en, second_channel_rx_en, biphase_tx_en;
  logic          self_test_active, diag_channel_pick, memory_inhibit, master_reset;
  status_flags_t status_flags;
  int            errors = 0;
  int            checked = 0;
  wire logic [15:0] outs = {10'h000, first_channel_rx_en, second_channel_rx_en,
                            memory_inhibit, diag_channel_pick, self_test_active, biphase_tx_en};

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (master_reset === 1'b1) mr_cnt++;

  remote_terminal_host_registers remote_terminal_host_registers_i (
    .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .host_in(host_in), .data_out(data_out),
    .data_oe(data_oe), .cmd_valid(cmd_valid), .cmd_in(cmd_in),
    .inhibit_flag_cmd(inhibit_flag_cmd), .override_inhibit_cmd(override_inhibit_cmd),
    .message_error_evt(message_error_evt), .message_error_cond(message_error_cond),
    .valid_message_evt(valid_message_evt), .addr_latch_load(addr_latch_load),
    .addr_parity_ok(addr_parity_ok), .transmitting_n(transmitting_n),
    .receiving_n(receiving_n),
    .command_strobe_n(command_strobe_n), .status_flags(status_flags),
    .first_channel_rx_en(first_channel_rx_en), .second_channel_rx_en(second_channel_rx_en),
    .biphase_tx_en(biphase_tx_en), .self_test_active(self_test_active),
    .diag_channel_pick(diag_channel_pick), .memory_inhibit(memory_inhibit),
    .master_reset(master_reset));

  host_cpu_model host_cpu_model_i (
    .clk_sys(clk_sys), .data_oe(data_oe), .data_out(data_out), .host_in(host_in));

  task automatic results();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic a0, output logic [15:0] q);
    logic to;
    host_cpu_model_i.access(1'b1, a0, 16'h0000, q, to);
    // A read that never sees data_oe ends the run
    if (to === 1'b1) begin
      errors++;
      results();
    end
  endtask

  task automatic rdc(input logic a0, input logic [15:0] exp);
    logic [15:0] q;
    rd(a0, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic a0, input logic [15:0] d);
    logic [15:0] q;
    logic        to;
    host_cpu_model_i.access(1'b0, a0, d, q, to);
  endtask

  task automatic pulse(ref logic s);
    @(posedge clk_sys);
    #1 s = 1'b1;
    @(posedge clk_sys);
    #1 s = 1'b0;
  endtask

  task automatic t_reset();
    rdc(1'b0, STATUS_RESET);
    rdc(1'b1, LAST_CMD_RESET);
    chk(outs, 16'h0001);
  endtask

  task automatic t_ctrl();
    int i;
    for (i = 0; i < 8; i++) begin
      // Upper byte is junk that must not reach any control bit
      wr(1'b0, {8'hA5, 8'h01 << i});
      @(posedge clk_sys);
      #1 command_strobe_n = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 command_strobe_n = 1'b1;
      repeat (6) @(posedge clk_sys);
      chk({12'h000, status_flags}, {12'h000, FLG_EXP[i]});
      chk(outs, {10'h000, OUT_EXP[i]});
      rdc(1'b0, ST_EXP[i]);
    end
    wr(1'b0, 16'h0000);
  endtask

  task automatic t_mreset();
    logic [15:0] m0;
    wr(1'b0, 16'h0049);
    // Count pulses relative to a snapshot; the counter has a single driver
    m0 = mr_cnt;
    wr(1'b1, 16'h0001);
    chk(mr_cnt - m0, 16'h0001);
    rdc(1'b0, STATUS_RESET);
    chk(outs, 16'h0001);
  endtask

  task automatic t_cmd();
    #1 cmd_in = '{11'h5A5, 5'h15, 1'b1, 1'b0, 1'b1};
    pulse(cmd_valid);
    rdc(1'b0, 16'h0235);
    rdc(1'b1, 16'hA5A5);
    pulse(inhibit_flag_cmd);
    rdc(1'b0, 16'h0035);
    pulse(override_inhibit_cmd);
    rdc(1'b0, 16'h0235);
  endtask

  task automatic t_sticky();
    #1 message_error_cond = 1'b1;
    pulse(valid_message_evt);
    pulse(message_error_evt);
    transmitting_n = 1'b0;
    rdc(1'b0, 16'hE235);
    #1 transmitting_n = 1'b1;
    rdc(1'b0, 16'h2235);
    #1 message_error_cond = 1'b0;
    repeat (3) @(posedge clk_sys);
    rdc(1'b0, 16'h0235);
    #1 receiving_n = 1'b0;
    rdc(1'b0, 16'h8235);
    #1 receiving_n = 1'b1;
  endtask

  task automatic t_parity();
    logic [15:0] q;
    wr(1'b0, 16'h0001);
    #1 addr_parity_ok = 1'b0;
    pulse(addr_latch_load);
    rdc(1'b0, 16'h3235);
    chk(outs, 16'h0001);
    #1 addr_parity_ok = 1'b1;
    pulse(addr_latch_load);
    // One plain read first, so the check does not hinge on when the held error drops
    rd(1'b0, q);
    rdc(1'b0, 16'h0335);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    #1 rst = 1'b0;
    t_reset();
    t_ctrl();
    t_mreset();
    t_cmd();
    t_sticky();
    t_parity();
    results();
  end
endmodule
`default_nettype wire
